// >>> core/mms_core.sv
// Contract
// RQ1: Reset starts fetching at address zero.
// RQ2: Enabled external interrupt vectors to 0x004.
// RQ3: Enabled timer overflow vectors to 0x008.
// RQ4: Enabled conversion-done interrupt vectors to 0x00C.
// RQ5: Program memory is 2048 words of 14.
// RQ6: Current-page table address uses PC[10:8].
// RQ7: Last-page table address forces top bits one.
// RQ8: Low byte to target, upper six bits high.
// RQ9: Table pointer read-write; high byte read-only.
// RQ10: Table reads take two cycles.
// RQ11: Six-level stack, invisible to software.
// RQ12: Calls and interrupts push; returns pop.
// RQ13: Stack empty after reset.
// RQ14: Full stack holds interrupt, flag still set.
// RQ15: Call when full overwrites oldest entry.
// RQ16: RAM 0x40-0x7F; unassigned low addresses read zero.
// RQ17: Special registers decoded at fixed addresses.
// RQ18: Every data bit settable and clearable; pointer bit 7 stays one and the table high byte ignores writes.
// RQ19: Address zero goes through pointer; self-reference null.
// RQ20: Pointer keeps seven bits; top reads one.
// RQ21: ALU ops update status flags.
// RQ22: Accumulator at 0x05, immediate operands supported.
// RQ23: Only program counter saved on entry.
// RQ24: Stack index wraps circularly, full stays set.
`timescale 1ns/1ps
`include "mms_params.svh"
module mms_core #(
   parameter int ROM_DEPTH = 2048,
   parameter int STACK_DEPTH = 6
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // Decoded instruction stream
   input wire logic cmd_vld,
   input wire mms_pkg::mms_cmd_type cmd,
   // Program memory loading
   input wire logic rom_we,
   input wire logic [10:0] rom_addr,
   input wire logic [13:0] rom_wdata,
   // Event sources
   input wire logic ext_int_n,
   input wire logic timer_ovf,
   input wire logic adc_eoc,
   // Core results
   output logic [10:0] pc_r,
   output logic [13:0] fetch_word_r,
   output logic fetch_vld_r,
   output logic [7:0] rd_data_r,
   output logic skip_r,
   output logic busy_r,
   output logic int_ack_r,
   output logic stack_full_r
);
   generate
      if (ROM_DEPTH != 2048 || STACK_DEPTH < 2 || STACK_DEPTH > 8) begin : g_bad
         $error("mms_core: unsupported depth parameters");
      end
   endgenerate

   localparam logic [3:0] SD4 = 4'(STACK_DEPTH);
   localparam logic [2:0] SD_LAST = 3'(STACK_DEPTH - 1);

   logic [13:0] rom [0:ROM_DEPTH-1];
   logic [7:0] ram [0:127];
   logic [10:0] stk [0:STACK_DEPTH-1];
   logic [7:0] acc_r;
   logic [7:0] table_address_low_r;
   logic [6:0] mp_r;
   logic [6:0] interrupt_control_r;
   logic [6:0] interrupt_control_nxt;
   logic [5:0] table_upper_bits_r;
   logic [3:0] stat_r;
   logic [3:0] stat_nxt;
   logic [3:0] cnt_r;
   logic [2:0] wp_r;
   logic [2:0] top;
   logic [10:0] top_val;
   mms_pkg::mms_state_type state_r;
   logic [6:0] tbl_dst_r;
   logic [13:0] tbl_word_r;
   logic [10:0] tbl_addr;
   logic int_s1_r;
   logic int_s2_r;
   logic int_s3_r;
   logic ext_fall;
   logic go;
   logic is_fetch;
   logic is_jump;
   logic is_call;
   logic is_ret;
   logic is_return_from_isr_op;
   logic is_tbl;
   logic is_alu;
   logic [6:0] ea;
   logic ind_null;
   logic [7:0] mem_rd;
   logic [7:0] b;
   logic [7:0] bb;
   logic cin;
   logic [8:0] sum;
   logic [4:0] nib;
   logic [8:0] d1;
   logic [8:0] d2;
   logic [7:0] alu_r;
   logic [3:0] flg;
   logic [3:0] upd;
   logic do_wr;
   logic do_skip;
   logic wr_en;
   logic [6:0] wr_a;
   logic [7:0] wr_d;
   logic int_e;
   logic int_t;
   logic int_a;
   logic take_int;
   logic [10:0] vec;
   logic [2:0] tbit;
   logic full;
   logic push;
   logic pop;

   function automatic logic is_store(input logic [6:0] a);
      case (a)
         `MMS_A_TMR, `MMS_A_TIMER_CONTROL, `MMS_A_PA, `MMS_A_PAC,
         `MMS_A_PB, `MMS_A_PBC, `MMS_A_PD, `MMS_A_PDC,
         `MMS_A_PWM, `MMS_A_ADC_RESULT_LOW, `MMS_A_ADC_RESULT_HIGH, `MMS_A_ADC_CONTROL,
         `MMS_A_ADC_CLOCK_SELECT: is_store = 1'b1;
         default: is_store = (a >= `MMS_RAM_BASE); // RQ16
      endcase
   endfunction

   // Commands are refused while a table read is in flight
   assign go = cmd_vld && (state_r == mms_pkg::MMS_S_IDLE);
   assign is_fetch = go && (cmd.op == mms_pkg::MMS_OP_FETCH);
   assign is_jump = go && (cmd.op == mms_pkg::MMS_OP_JUMP);
   assign is_call = go && (cmd.op == mms_pkg::MMS_OP_CALL);
   assign is_ret = go && (cmd.op == mms_pkg::MMS_OP_RET);
   assign is_return_from_isr_op = go && (cmd.op == mms_pkg::MMS_OP_RETURN_FROM_ISR_OP);
   assign is_tbl = go && (cmd.op == mms_pkg::MMS_OP_TBRC || cmd.op == mms_pkg::MMS_OP_TBRL);
   assign is_alu = go && (cmd.op == mms_pkg::MMS_OP_ALU);

   assign ea = (cmd.addr == `MMS_A_IND) ? mp_r : cmd.addr; // RQ19
   assign ind_null = (ea == `MMS_A_IND); // RQ19

   always_comb begin
      case (ea)
         `MMS_A_IND: mem_rd = 8'h00; // RQ19
         `MMS_A_MP: mem_rd = {1'b1, mp_r}; // RQ20
         `MMS_A_ACC: mem_rd = acc_r; // RQ22
         `MMS_A_PCL: mem_rd = pc_r[7:0]; // RQ17
         `MMS_A_TABLE_ADDRESS_LOW: mem_rd = table_address_low_r; // RQ9
         `MMS_A_TABLE_UPPER_BITS: mem_rd = {2'h0, table_upper_bits_r}; // RQ8
         `MMS_A_STAT: mem_rd = {4'h0, stat_r}; // RQ17
         `MMS_A_INTERRUPT_CONTROL: mem_rd = {1'b0, interrupt_control_r}; // RQ17
         // The stack has no address and never appears here
         default: mem_rd = is_store(ea) ? ram[ea] : 8'h00; // RQ16 RQ11
      endcase
   end

   // One shared adder serves add and subtract; subtract inverts b
   always_comb begin
      b = cmd.src_imm ? cmd.imm : mem_rd; // RQ22
      bb = (cmd.fn == mms_pkg::MMS_FN_SUB || cmd.fn == mms_pkg::MMS_FN_SBC) ? ~b : b;
      case (cmd.fn)
         mms_pkg::MMS_FN_ADD: cin = 1'b0;
         mms_pkg::MMS_FN_SUB: cin = 1'b1;
         default: cin = stat_r[`MMS_ST_C];
      endcase
      sum = {1'b0, acc_r} + {1'b0, bb} + {8'h00, cin};
      nib = {1'b0, acc_r[3:0]} + {1'b0, bb[3:0]} + {4'h0, cin};
      d1 = {1'b0, acc_r};
      if (acc_r[3:0] > 4'h9 || stat_r[`MMS_ST_AC]) begin
         d1 = d1 + 9'h006;
      end
      d2 = d1;
      if (d1[7:4] > 4'h9 || stat_r[`MMS_ST_C] || d1[8]) begin
         d2 = d1 + 9'h060;
      end
      alu_r = b;
      flg = stat_r;
      upd = 4'h0;
      do_wr = 1'b1;
      do_skip = 1'b0;
      case (cmd.fn) // RQ21
         mms_pkg::MMS_FN_ADD, mms_pkg::MMS_FN_ADC,
         mms_pkg::MMS_FN_SUB, mms_pkg::MMS_FN_SBC: begin
            alu_r = sum[7:0];
            flg[`MMS_ST_C] = sum[8];
            flg[`MMS_ST_AC] = nib[4];
            flg[`MMS_ST_OV] = (acc_r[7] == bb[7]) && (sum[7] != acc_r[7]);
            upd = 4'hF;
         end
         mms_pkg::MMS_FN_DAA: begin
            alu_r = d2[7:0];
            flg[`MMS_ST_C] = d2[8] | d1[8];
            upd = 4'h1;
         end
         mms_pkg::MMS_FN_AND: begin
            alu_r = acc_r & b;
            upd = 4'h4;
         end
         mms_pkg::MMS_FN_OR: begin
            alu_r = acc_r | b;
            upd = 4'h4;
         end
         mms_pkg::MMS_FN_XOR: begin
            alu_r = acc_r ^ b;
            upd = 4'h4;
         end
         mms_pkg::MMS_FN_CPL: begin
            alu_r = ~b;
            upd = 4'h4;
         end
         mms_pkg::MMS_FN_RL: alu_r = {b[6:0], b[7]};
         mms_pkg::MMS_FN_RR: alu_r = {b[0], b[7:1]};
         mms_pkg::MMS_FN_RLC: begin
            alu_r = {b[6:0], stat_r[`MMS_ST_C]};
            flg[`MMS_ST_C] = b[7];
            upd = 4'h1;
         end
         mms_pkg::MMS_FN_RRC: begin
            alu_r = {stat_r[`MMS_ST_C], b[7:1]};
            flg[`MMS_ST_C] = b[0];
            upd = 4'h1;
         end
         mms_pkg::MMS_FN_INC: begin
            alu_r = b + 8'h01;
            upd = 4'h4;
         end
         mms_pkg::MMS_FN_DEC: begin
            alu_r = b - 8'h01;
            upd = 4'h4;
         end
         mms_pkg::MMS_FN_SETB: alu_r = b | (8'h01 << cmd.bitsel); // RQ18
         mms_pkg::MMS_FN_CLRB: alu_r = b & ~(8'h01 << cmd.bitsel); // RQ18
         mms_pkg::MMS_FN_STORE: alu_r = acc_r; // RQ22
         mms_pkg::MMS_FN_SZ: begin
            do_wr = 1'b0;
            do_skip = (b == 8'h00);
         end
         mms_pkg::MMS_FN_SNZ: begin
            do_wr = 1'b0;
            do_skip = (b != 8'h00);
         end
         mms_pkg::MMS_FN_SIZ: begin
            alu_r = b + 8'h01;
            do_skip = (alu_r == 8'h00);
         end
         mms_pkg::MMS_FN_SDZ: begin
            alu_r = b - 8'h01;
            do_skip = (alu_r == 8'h00);
         end
         default: alu_r = b;
      endcase
      flg[`MMS_ST_Z] = (alu_r == 8'h00);
   end

   // Single data write port; the table completion owns it while busy
   always_comb begin
      if (state_r == mms_pkg::MMS_S_TBL) begin
         wr_en = (tbl_dst_r != `MMS_A_IND);
         wr_a = tbl_dst_r;
         wr_d = tbl_word_r[7:0]; // RQ8
      end else begin
         wr_en = is_alu && do_wr && cmd.dst_mem && !ind_null; // RQ19
         wr_a = ea;
         wr_d = alu_r;
      end
   end

   // Interrupt selection, fixed priority external, timer, converter
   assign int_e = interrupt_control_r[`MMS_INT_EMI] && interrupt_control_r[`MMS_INT_EEI] && interrupt_control_r[`MMS_INT_EIF];
   assign int_t = interrupt_control_r[`MMS_INT_EMI] && interrupt_control_r[`MMS_INT_ETI] && interrupt_control_r[`MMS_INT_TF];
   assign int_a = interrupt_control_r[`MMS_INT_EMI] && interrupt_control_r[`MMS_INT_EADI] && interrupt_control_r[`MMS_INT_ADF];
   assign full = (cnt_r == SD4);
   assign take_int = is_fetch && (int_e || int_t || int_a) && !full; // RQ14

   always_comb begin
      if (int_e) begin
         vec = `MMS_VEC_EXT; // RQ2
         tbit = `MMS_INT_EIF;
      end else if (int_t) begin
         vec = `MMS_VEC_TMR; // RQ3
         tbit = `MMS_INT_TF;
      end else begin
         vec = `MMS_VEC_ADC; // RQ4
         tbit = `MMS_INT_ADF;
      end
   end

   assign push = take_int || is_call; // RQ12
   assign pop = is_ret || is_return_from_isr_op; // RQ12
   assign top = (wp_r == 3'h0) ? SD_LAST : wp_r - 3'h1;
   assign top_val = stk[top];
   assign tbl_addr = (cmd.op == mms_pkg::MMS_OP_TBRL) ?
      {`MMS_LAST_PAGE, table_address_low_r} : {pc_r[10:8], table_address_low_r}; // RQ6 RQ7

   // Pin passes two flops before the edge detector looks at it
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         int_s1_r <= 1'b1;
         int_s2_r <= 1'b1;
         int_s3_r <= 1'b1;
      end else begin
         int_s1_r <= ext_int_n;
         int_s2_r <= int_s1_r;
         int_s3_r <= int_s2_r;
      end
   end
   assign ext_fall = int_s3_r && !int_s2_r;

   always_ff @(posedge core_clk) begin
      if (rom_we) begin
         rom[rom_addr] <= rom_wdata; // RQ5
      end
   end

   always_ff @(posedge core_clk) begin
      if (wr_en && is_store(wr_a)) begin
         ram[wr_a] <= wr_d; // RQ16
      end
   end

   // Only the program counter goes on the stack, never status
   always_ff @(posedge core_clk) begin
      if (push) begin
         stk[wp_r] <= pc_r; // RQ23 RQ15
      end
   end

   // Index wraps so a push on a full stack drops the oldest entry
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         wp_r <= 3'h0; // RQ13
         cnt_r <= 4'h0; // RQ13
         stack_full_r <= 1'b0;
      end else if (push) begin
         wp_r <= (wp_r == SD_LAST) ? 3'h0 : wp_r + 3'h1; // RQ24
         if (!full) begin
            cnt_r <= cnt_r + 4'h1;
         end
         stack_full_r <= full || (cnt_r == SD4 - 4'h1); // RQ24
      end else if (pop) begin
         wp_r <= top; // RQ12
         if (cnt_r != 4'h0) begin
            cnt_r <= cnt_r - 4'h1;
         end
         stack_full_r <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         pc_r <= `MMS_RESET_PC; // RQ1
      end else if (take_int) begin
         pc_r <= vec; // RQ2 RQ3 RQ4
      end else if (is_fetch) begin
         pc_r <= pc_r + 11'h001; // RQ5
      end else if (is_jump || is_call) begin
         pc_r <= cmd.target;
      end else if (pop) begin
         pc_r <= top_val; // RQ12
      end else if (is_alu && do_skip) begin
         pc_r <= pc_r + 11'h001; // RQ21
      end else if (wr_en && wr_a == `MMS_A_PCL) begin
         pc_r <= {pc_r[10:8], wr_d};
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         fetch_word_r <= 14'h0000;
         fetch_vld_r <= 1'b0;
         int_ack_r <= 1'b0;
      end else begin
         fetch_vld_r <= is_fetch && !take_int;
         int_ack_r <= take_int;
         if (is_fetch && !take_int) begin
            fetch_word_r <= rom[pc_r]; // RQ5
         end
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         state_r <= mms_pkg::MMS_S_IDLE;
         busy_r <= 1'b0;
         tbl_word_r <= 14'h0000;
         tbl_dst_r <= 7'h00;
         table_upper_bits_r <= 6'h00;
      end else begin
         case (state_r)
            mms_pkg::MMS_S_IDLE: begin
               if (is_tbl) begin
                  tbl_word_r <= rom[tbl_addr]; // RQ6 RQ7
                  tbl_dst_r <= ea;
                  state_r <= mms_pkg::MMS_S_TBL; // RQ10
                  busy_r <= 1'b1;
               end
            end
            mms_pkg::MMS_S_TBL: begin
               table_upper_bits_r <= tbl_word_r[13:8]; // RQ8
               state_r <= mms_pkg::MMS_S_IDLE; // RQ10
               busy_r <= 1'b0;
            end
            default: begin
               state_r <= mms_pkg::MMS_S_IDLE;
               busy_r <= 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         acc_r <= `MMS_RST_BYTE;
      end else if (is_alu && do_wr && !cmd.dst_mem) begin
         acc_r <= alu_r; // RQ22
      end else if (wr_en && wr_a == `MMS_A_ACC) begin
         acc_r <= wr_d; // RQ22
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         mp_r <= 7'h00;
         table_address_low_r <= `MMS_RST_BYTE;
      end else begin
         if (wr_en && wr_a == `MMS_A_MP) begin
            mp_r <= wr_d[6:0]; // RQ20
         end
         if (wr_en && wr_a == `MMS_A_TABLE_ADDRESS_LOW) begin
            table_address_low_r <= wr_d; // RQ9
         end
      end
   end

   // Flag results win over a write that targets status itself
   always_comb begin
      stat_nxt = stat_r;
      if (wr_en && wr_a == `MMS_A_STAT) begin
         stat_nxt = wr_d[3:0];
      end
      if (is_alu) begin
         stat_nxt = (stat_nxt & ~upd) | (flg & upd); // RQ21
      end
   end

   // Hardware sets are applied last so they beat a clear
   always_comb begin
      interrupt_control_nxt = interrupt_control_r;
      if (wr_en && wr_a == `MMS_A_INTERRUPT_CONTROL) begin
         interrupt_control_nxt = wr_d[6:0];
      end
      if (take_int) begin
         interrupt_control_nxt[`MMS_INT_EMI] = 1'b0;
         interrupt_control_nxt[tbit] = 1'b0;
      end
      if (is_return_from_isr_op) begin
         interrupt_control_nxt[`MMS_INT_EMI] = 1'b1;
      end
      if (ext_fall) begin
         interrupt_control_nxt[`MMS_INT_EIF] = 1'b1; // RQ14
      end
      if (timer_ovf) begin
         interrupt_control_nxt[`MMS_INT_TF] = 1'b1; // RQ14
      end
      if (adc_eoc) begin
         interrupt_control_nxt[`MMS_INT_ADF] = 1'b1; // RQ14
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         stat_r <= 4'h0;
         interrupt_control_r <= 7'h00;
      end else begin
         stat_r <= stat_nxt;
         interrupt_control_r <= interrupt_control_nxt;
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rd_data_r <= `MMS_RST_BYTE;
         skip_r <= 1'b0;
      end else begin
         skip_r <= is_alu && do_skip;
         if (is_alu) begin
            rd_data_r <= mem_rd;
         end
      end
   end

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rstn);

   chk_ext_vector: assert property (take_int && int_e |=> pc_r == `MMS_VEC_EXT && int_ack_r) // RQ2
      else $error("external interrupt did not vector to 0x004");
   chk_tmr_vector: assert property (take_int && !int_e && int_t |=> pc_r == `MMS_VEC_TMR) // RQ3
      else $error("timer interrupt did not vector to 0x008");
   chk_adc_vector: assert property (take_int && !int_e && !int_t |=> pc_r == `MMS_VEC_ADC) // RQ4
      else $error("converter interrupt did not vector to 0x00C");
   chk_full_inhibit: assert property (is_fetch && full |=> !int_ack_r && fetch_vld_r) // RQ14
      else $error("interrupt taken with full stack");
   chk_table_two: assert property (is_tbl |=> busy_r ##1 !busy_r) // RQ10
      else $error("table read not two cycles");
   chk_table_upper_bits_load: assert property (state_r == mms_pkg::MMS_S_TBL |=>
      table_upper_bits_r == $past(tbl_word_r[13:8])) // RQ8
      else $error("table high byte not loaded");
   chk_ptr_msb: assert property (is_alu && !ind_null && ea == `MMS_A_MP |=> rd_data_r[7]) // RQ20
      else $error("pointer bit 7 not one");
   chk_ind_null: assert property (is_alu && ind_null |=> rd_data_r == 8'h00) // RQ19
      else $error("self-indirect read not zero");
   chk_ret_restore: assert property (pop |=> pc_r == $past(top_val)) // RQ12
      else $error("return did not restore pc");
   chk_depth_cap: assert property (push && full |=> cnt_r == SD4 && stack_full_r) // RQ15
      else $error("full stack count changed on push");
   cov_ext_take: cover property (take_int && int_e);
   cov_tbl_read: cover property (is_tbl ##2 busy_r == 1'b0);
   cov_full_call: cover property (is_call && full);
endmodule

// >>> pkg/mms_params.svh
`ifndef MMS_PARAMS_SVH
`define MMS_PARAMS_SVH
`define MMS_RESET_PC 11'h000
`define MMS_VEC_EXT 11'h004
`define MMS_VEC_TMR 11'h008
`define MMS_VEC_ADC 11'h00C
`define MMS_LAST_PAGE 3'h7
`define MMS_A_IND 7'h00
`define MMS_A_MP 7'h01
`define MMS_A_ACC 7'h05
`define MMS_A_PCL 7'h06
`define MMS_A_TABLE_ADDRESS_LOW 7'h07
`define MMS_A_TABLE_UPPER_BITS 7'h08
`define MMS_A_STAT 7'h0A
`define MMS_A_INTERRUPT_CONTROL 7'h0B
`define MMS_A_TMR 7'h0D
`define MMS_A_TIMER_CONTROL 7'h0E
`define MMS_A_PA 7'h12
`define MMS_A_PAC 7'h13
`define MMS_A_PB 7'h14
`define MMS_A_PBC 7'h15
`define MMS_A_PD 7'h18
`define MMS_A_PDC 7'h19
`define MMS_A_PWM 7'h1A
`define MMS_A_ADC_RESULT_LOW 7'h20
`define MMS_A_ADC_RESULT_HIGH 7'h21
`define MMS_A_ADC_CONTROL 7'h22
`define MMS_A_ADC_CLOCK_SELECT 7'h23
`define MMS_RAM_BASE 7'h40
`define MMS_INT_EMI 3'h0
`define MMS_INT_EEI 3'h1
`define MMS_INT_ETI 3'h2
`define MMS_INT_EADI 3'h3
`define MMS_INT_EIF 3'h4
`define MMS_INT_TF 3'h5
`define MMS_INT_ADF 3'h6
`define MMS_ST_C 2'h0
`define MMS_ST_AC 2'h1
`define MMS_ST_Z 2'h2
`define MMS_ST_OV 2'h3
`define MMS_RST_BYTE 8'h00
`endif

// >>> pkg/mms_pkg.sv
package mms_pkg;
   typedef enum logic [3:0] {
      MMS_OP_NOP = 4'h0, MMS_OP_FETCH = 4'h1, MMS_OP_JUMP = 4'h2,
      MMS_OP_CALL = 4'h3, MMS_OP_RET = 4'h4, MMS_OP_RETURN_FROM_ISR_OP = 4'h5,
      MMS_OP_TBRC = 4'h6, MMS_OP_TBRL = 4'h7, MMS_OP_ALU = 4'h8
   } mms_op_type;
   typedef enum logic [4:0] {
      MMS_FN_ADD = 5'h00, MMS_FN_ADC = 5'h01, MMS_FN_SUB = 5'h02,
      MMS_FN_SBC = 5'h03, MMS_FN_DAA = 5'h04, MMS_FN_AND = 5'h05,
      MMS_FN_OR = 5'h06, MMS_FN_XOR = 5'h07, MMS_FN_CPL = 5'h08,
      MMS_FN_RL = 5'h09, MMS_FN_RR = 5'h0A, MMS_FN_RLC = 5'h0B,
      MMS_FN_RRC = 5'h0C, MMS_FN_INC = 5'h0D, MMS_FN_DEC = 5'h0E,
      MMS_FN_SETB = 5'h0F, MMS_FN_CLRB = 5'h10, MMS_FN_MOVE = 5'h11,
      MMS_FN_STORE = 5'h12, MMS_FN_SZ = 5'h13, MMS_FN_SNZ = 5'h14,
      MMS_FN_SIZ = 5'h15, MMS_FN_SDZ = 5'h16
   } mms_fn_type;
   typedef enum logic {
      MMS_S_IDLE = 1'b0,
      MMS_S_TBL = 1'b1
   } mms_state_type;
   typedef struct packed {
      mms_op_type op;
      mms_fn_type fn;
      logic src_imm;
      logic dst_mem;
      logic [2:0] bitsel;
      logic [6:0] addr;
      logic [7:0] imm;
      logic [10:0] target;
   } mms_cmd_type;
endpackage

// >>> bench/mms_core_tb.sv
`timescale 1ns/1ps
module mms_core_tb;
   logic core_clk;
   logic rstn;
   logic cmd_vld;
   mms_pkg::mms_cmd_type cmd;
   logic rom_we;
   logic [10:0] rom_addr;
   logic [13:0] rom_wdata;
   logic ext_int_n;
   logic timer_ovf;
   logic adc_eoc;
   logic [10:0] pc_r;
   logic [13:0] fetch_word_r;
   logic fetch_vld_r;
   logic [7:0] rd_data_r;
   logic skip_r;
   logic busy_r;
   logic int_ack_r;
   logic stack_full_r;
   int errors = 0;
   int total_checks = 0;
   int i;

   mms_core dut (.core_clk(core_clk), .rstn(rstn), .cmd_vld(cmd_vld), .cmd(cmd),
      .rom_we(rom_we), .rom_addr(rom_addr), .rom_wdata(rom_wdata), .ext_int_n(ext_int_n),
      .timer_ovf(timer_ovf), .adc_eoc(adc_eoc), .pc_r(pc_r), .fetch_word_r(fetch_word_r),
      .fetch_vld_r(fetch_vld_r), .rd_data_r(rd_data_r), .skip_r(skip_r), .busy_r(busy_r),
      .int_ack_r(int_ack_r), .stack_full_r(stack_full_r));

   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end

   task automatic ck(input string n, input logic [13:0] s, input logic [13:0] e);
      total_checks++;
      if (s !== e) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask

   task automatic print_verdict();
      $display("errors %0d total_checks %0d", errors, total_checks);
      if (errors == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // One command, held for the accepting edge; outputs sampled 1 ns after that edge
   task automatic go(input mms_pkg::mms_op_type o, input mms_pkg::mms_fn_type fn,
      input logic si, input logic dm, input logic [2:0] b, input logic [6:0] a,
      input logic [7:0] im, input logic [10:0] t);
      @(posedge core_clk);
      cmd_vld <= 1'b1;
      cmd <= '{o, fn, si, dm, b, a, im, t};
      @(posedge core_clk);
      cmd_vld <= 1'b0;
      #1;
   endtask

   task automatic alu(input mms_pkg::mms_fn_type fn, input logic si, input logic dm,
      input logic [2:0] b, input logic [6:0] a, input logic [7:0] im);
      go(mms_pkg::MMS_OP_ALU, fn, si, dm, b, a, im, 11'h000);
   endtask

   task automatic op(input mms_pkg::mms_op_type o, input logic [6:0] a, input logic [10:0] t);
      go(o, mms_pkg::MMS_FN_MOVE, 1'b0, 1'b0, 3'h0, a, 8'h00, t);
   endtask

   // Moves between memory places must pass through the accumulator
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      alu(mms_pkg::MMS_FN_MOVE, 1'b1, 1'b0, 3'h0, 7'h00, d);
      alu(mms_pkg::MMS_FN_STORE, 1'b0, 1'b1, 3'h0, a, 8'h00);
   endtask

   task automatic rd(input logic [6:0] a, input logic [7:0] e);
      alu(mms_pkg::MMS_FN_MOVE, 1'b0, 1'b0, 3'h0, a, 8'h00);
      ck("read byte", {6'h00, rd_data_r}, {6'h00, e});
   endtask

   task automatic rom(input logic [10:0] a, input logic [13:0] d);
      @(posedge core_clk);
      rom_we <= 1'b1;
      rom_addr <= a;
      rom_wdata <= d;
      @(posedge core_clk);
      rom_we <= 1'b0;
   endtask

   task automatic t_fetch_table();
      rom(11'h000, 14'h2A55);
      rom(11'h0AB, 14'h1F81);
      rom(11'h7AB, 14'h3ABC);
      op(mms_pkg::MMS_OP_FETCH, 7'h00, 11'h000);
      ck("fetch word", fetch_word_r, 14'h2A55);
      ck("fetch valid", {13'h0, fetch_vld_r}, 14'h1);
      wr(7'h07, 8'hAB);
      rd(7'h07, 8'hAB);
      op(mms_pkg::MMS_OP_TBRC, 7'h40, 11'h000);
      ck("busy first", {13'h0, busy_r}, 14'h1);
      @(posedge core_clk);
      #1;
      ck("busy second", {13'h0, busy_r}, 14'h0);
      rd(7'h40, 8'h81);
      rd(7'h08, 8'h1F);
      op(mms_pkg::MMS_OP_TBRL, 7'h41, 11'h000);
      @(posedge core_clk);
      rd(7'h41, 8'hBC);
      rd(7'h08, 8'h3A);
      wr(7'h08, 8'hFF);
      rd(7'h08, 8'h3A);
      // A page other than zero shows that the current page comes from the pc
      rom(11'h2AB, 14'h0C33);
      op(mms_pkg::MMS_OP_JUMP, 7'h00, 11'h2F0);
      ck("jump pc", {3'h0, pc_r}, 14'h2F0);
      op(mms_pkg::MMS_OP_TBRC, 7'h43, 11'h000);
      @(posedge core_clk);
      rd(7'h43, 8'h33);
   endtask

   task automatic t_data_map();
      wr(7'h01, 8'h45);
      rd(7'h01, 8'hC5);
      wr(7'h00, 8'h5A);
      rd(7'h45, 8'h5A);
      wr(7'h01, 8'h00);
      wr(7'h00, 8'h77);
      rd(7'h00, 8'h00);
      wr(7'h02, 8'hFF);
      rd(7'h02, 8'h00);
      wr(7'h7F, 8'h3C);
      rd(7'h7F, 8'h3C);
      wr(7'h12, 8'hA5);
      rd(7'h12, 8'hA5);
      wr(7'h42, 8'h00);
      alu(mms_pkg::MMS_FN_SETB, 1'b0, 1'b1, 3'h7, 7'h42, 8'h00);
      rd(7'h42, 8'h80);
      alu(mms_pkg::MMS_FN_CLRB, 1'b0, 1'b1, 3'h7, 7'h42, 8'h00);
      rd(7'h42, 8'h00);
      wr(7'h06, 8'h30);
      ck("short jump", {3'h0, pc_r}, 14'h230);
      alu(mms_pkg::MMS_FN_SZ, 1'b0, 1'b0, 3'h0, 7'h42, 8'h00);
      ck("skip taken", {13'h0, skip_r}, 14'h1);
      ck("skip pc", {3'h0, pc_r}, 14'h231);
      alu(mms_pkg::MMS_FN_SNZ, 1'b0, 1'b0, 3'h0, 7'h42, 8'h00);
      ck("skip not taken", {13'h0, skip_r}, 14'h0);
      alu(mms_pkg::MMS_FN_MOVE, 1'b1, 1'b0, 3'h0, 7'h00, 8'hFF);
      alu(mms_pkg::MMS_FN_ADD, 1'b1, 1'b0, 3'h0, 7'h00, 8'h01);
      rd(7'h05, 8'h00);
      rd(7'h0A, 8'h07);
   endtask

   // Seven calls into six levels, with a timer request held off while full
   task automatic t_stack();
      for (i = 0; i < 7; i++) begin
         op(mms_pkg::MMS_OP_CALL, 7'h00, 11'h100 + 11'(i));
      end
      ck("stack full", {13'h0, stack_full_r}, 14'h1);
      wr(7'h0B, 8'h05);
      @(posedge core_clk);
      timer_ovf <= 1'b1;
      @(posedge core_clk);
      timer_ovf <= 1'b0;
      op(mms_pkg::MMS_OP_FETCH, 7'h00, 11'h000);
      ck("held ack", {13'h0, int_ack_r}, 14'h0);
      rd(7'h0B, 8'h25);
      op(mms_pkg::MMS_OP_RET, 7'h00, 11'h000);
      ck("pop newest", {3'h0, pc_r}, 14'h105);
      ck("not full", {13'h0, stack_full_r}, 14'h0);
      op(mms_pkg::MMS_OP_FETCH, 7'h00, 11'h000);
      ck("timer ack", {13'h0, int_ack_r}, 14'h1);
      ck("timer vector", {3'h0, pc_r}, 14'h008);
      op(mms_pkg::MMS_OP_RETURN_FROM_ISR_OP, 7'h00, 11'h000);
      for (i = 4; i >= 0; i--) begin
         op(mms_pkg::MMS_OP_RET, 7'h00, 11'h000);
         ck("pop order", {3'h0, pc_r}, 14'h100 + 14'(i));
      end
   endtask

   task automatic t_ext_adc();
      wr(7'h0B, 8'h03);
      @(posedge core_clk);
      ext_int_n <= 1'b0;
      repeat (5) @(posedge core_clk);
      op(mms_pkg::MMS_OP_FETCH, 7'h00, 11'h000);
      ck("ext vector", {3'h0, pc_r}, 14'h004);
      @(posedge core_clk);
      ext_int_n <= 1'b1;
      rd(7'h0B, 8'h02);
      wr(7'h0B, 8'h09);
      @(posedge core_clk);
      adc_eoc <= 1'b1;
      @(posedge core_clk);
      adc_eoc <= 1'b0;
      op(mms_pkg::MMS_OP_FETCH, 7'h00, 11'h000);
      ck("adc vector", {3'h0, pc_r}, 14'h00C);
   endtask

   initial begin
      rstn = 1'b0;
      cmd_vld = 1'b0;
      cmd = '0;
      rom_we = 1'b0;
      rom_addr = 11'h000;
      rom_wdata = 14'h0000;
      ext_int_n = 1'b1;
      timer_ovf = 1'b0;
      adc_eoc = 1'b0;
      repeat (5) @(posedge core_clk);
      rstn <= 1'b1;
      #1;
      ck("reset pc", {3'h0, pc_r}, 14'h000);
      ck("reset stack", {13'h0, stack_full_r}, 14'h0);
      t_fetch_table();
      t_data_map();
      t_stack();
      t_ext_adc();
      print_verdict();
   end

   // The whole run is under two hundred cycles; this cuts a hang short
   initial begin
      #20000;
      errors++;
      print_verdict();
   end
endmodule
